// ---- logic/ocs_clk_out.sv ----
// output stage: quad_rate_clock and double_rate_clock from the selected source level
// assumes src_lvl_i is already glitch-free and sampled on ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module ocs_clk_out (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic src_lvl_i,
  input wire logic stop_mode_i,
  output logic quad_rate_clock_o,
  output logic double_rate_clock_o
);

  logic run_r;
  logic run_nxt;
  logic quad_r;
  logic quad_nxt;
  logic double_r;
  logic double_nxt;

  // ********************************
  // gating and division
  // ********************************
  // stop gate only moves while the source is low, so no high phase is cut short
  always_comb begin
    run_nxt = src_lvl_i ? run_r : ~stop_mode_i; // [R17]
    quad_nxt = src_lvl_i & run_r; // [R14]
    double_nxt = (quad_nxt & ~quad_r) ? ~double_r : double_r; // [R15]
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_r <= 1'b1;
      quad_r <= 1'b0;
      double_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      quad_r <= quad_nxt;
      double_r <= double_nxt;
    end
  end

  assign quad_rate_clock_o = quad_r;
  assign double_rate_clock_o = double_r;

  // ********************************
  // checks
  // ********************************
  chk_double_half: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R15]
    $rose(quad_r) |-> $changed(double_r))
    else $error("double rate clock did not toggle on quad rising edge");

  chk_stop_low: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R17]
    (!run_r && !src_lvl_i) |=> !quad_r)
    else $error("quad rate clock ran while stopped");

endmodule // ocs_clk_out
`default_nettype wire

// ---- logic/ocs_pkg.sv ----
// clock source select and switch-over: shared constants, states and carriers
// assumes a single 125 MHz register clock; source clocks arrive as sampled levels
package ocs_pkg;

  // ********************************
  // register port
  // ********************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] ADDR_OSC_STATUS = 4'h0;
  localparam logic [3:0] ADDR_SECOND_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_PORT_A_PULLUP = 4'h2;

  // oscillator_status_register fields
  localparam int BIT_EXT_REQUEST = 0;
  localparam int BIT_EXT_ENGAGED = 1;
  // second_config_register field clock_source_select[1:0]
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 1;
  // port_a_pullup_register field clock_output_pin_select
  localparam int BIT_PIN_SELECT = 7;

  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // ********************************
  // clock source codes
  // ********************************
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL = 2'h1;
  localparam logic [1:0] SRC_RC = 2'h2;
  localparam logic [1:0] SRC_CRYSTAL = 2'h3;
  localparam logic [1:0] SEL_RESET = SRC_INTERNAL;

  // rising edges of the new source seen before the switch
  localparam logic [1:0] EDGES_NEEDED = 2'h2;
  localparam logic [1:0] EDGE_ZERO = 2'h0;
  localparam logic [1:0] EDGE_ONE = 2'h1;

  // nominal internal oscillator frequency, kHz
  localparam int INTERNAL_NOMINAL_KHZ = 12800;

  // ********************************
  // types
  // ********************************
  typedef enum logic [2:0] {
    OCS_ST_INTERNAL,
    OCS_ST_CHECK,
    OCS_ST_SWAP,
    OCS_ST_HALT,
    OCS_ST_EXTERNAL
  } ocs_state_t;

  typedef struct packed {
    logic internal_en;
    logic rc_en;
    logic crystal_en;
  } ocs_osc_en_t;

  typedef struct packed {
    logic drive;
    logic oe;
  } ocs_pin_t;

endpackage

// ---- logic/ocs_switch.sv ----
// clock source select, internal-to-external switch-over and clock pin control
// assumes source clocks and pins are sampled synchronously to ref_clk_i
// Function
// R1: software may precharge a crystal by driving port A bit four high first.
// R2: a non-internal source makes the input pin a clock input; crystal owns output pin.
// R3: software waits for the external source to settle, about 4096 crystal cycles.
// R4: software then sets the external clock request bit.
// R5: after the request, two rising edges of the new source are awaited.
// R6: the switch from internal to external clock is glitch-free.
// R7: engaged status is set first, then the internal oscillator is stopped.
// R8: once switched, only reset restarts the internal oscillator.
// R9: no clock monitor after the switch and no fallback to internal.
// R10: external mode uses the input pin as quad rate, halved for double rate.
// R11: internal or RC: pin select picks port bit or quad clock; crystal: amplifier output.
// R12: external mode dedicates the output pin to port A bit four; select ignored.
// R13: oscillator run enable gates the crystal, RC or internal oscillator in use.
// R14: quad rate clock equals the selected source clock.
// R15: double rate clock is half the quad rate clock.
// R16: wait mode leaves the oscillator and both output clocks running.
// R17: stop mode stops the source output and so both clocks.
// R18: break state keeps both clocks running.
// R19: select codes: 00 internal, 01 external, 10 RC, 11 crystal.
// R20: internal oscillator is nominally 12.8 MHz, trimmable.
// R21: reset clears the request; it is ignored in bypass and test modes. Here only bypass_mode_i blocks it; there is no test mode input.
// R22: engaged bit is read-only, one while an external source drives the clock.
// R23: out of reset the internal oscillator is the source.
// R24: with internal selected, the request causes no switch.
`timescale 1ns/1ps
`default_nettype none
module ocs_switch (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [ocs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [ocs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [ocs_pkg::DATA_W-1:0] reg_rdata_o,
  // source clocks
  input wire logic internal_clock_i,
  input wire logic rc_clock_i,
  input wire logic crystal_clock_i,
  input wire logic osc_input_pin_i,
  // system integration unit
  input wire logic oscillator_run_enable_i,
  input wire logic stop_mode_i,
  input wire logic bypass_mode_i,
  output logic quad_rate_clock_o,
  output logic double_rate_clock_o,
  output ocs_pkg::ocs_osc_en_t osc_en_o,
  output logic osc_input_is_clock_o,
  // clock output pin and port A bit four
  input wire logic osc_output_pin_i,
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe_o,
  output logic crystal_amp_on_pin_o,
  input wire logic port_a_bit_four_out_i,
  input wire logic port_a_bit_four_oe_i,
  output logic port_a_bit_four_in_o
);

  // ********************************
  // register file
  // ********************************
  logic req_r;
  logic req_nxt;
  logic [1:0] sel_r;
  logic [1:0] sel_nxt;
  logic pin_sel_r;
  logic pin_sel_nxt;
  logic [ocs_pkg::DATA_W-1:0] rdata_r;
  logic [ocs_pkg::DATA_W-1:0] rdata_nxt;

  ocs_pkg::ocs_state_t state_r;
  ocs_pkg::ocs_state_t state_nxt;
  logic [1:0] edge_cnt_r;
  logic [1:0] edge_cnt_nxt;
  logic use_ext_r;
  logic use_ext_nxt;
  logic engaged_r;
  logic engaged_nxt;
  logic int_off_r;
  logic int_off_nxt;
  logic ext_prev_r;
  logic ext_lvl;
  logic ext_rise;
  logic src_lvl;
  ocs_pkg::ocs_pin_t pin;

  always_comb begin
    req_nxt = req_r;
    sel_nxt = sel_r;
    pin_sel_nxt = pin_sel_r;
    rdata_nxt = ocs_pkg::DATA_ZERO;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ocs_pkg::ADDR_OSC_STATUS: begin
          req_nxt = reg_wdata_i[ocs_pkg::BIT_EXT_REQUEST]; // [R4]
        end
        ocs_pkg::ADDR_SECOND_CONFIG: begin
          // source is frozen once a switch is under way, so the mux never sees a new input mid-switch
          if (state_r == ocs_pkg::OCS_ST_INTERNAL) begin
            sel_nxt = reg_wdata_i[ocs_pkg::SEL_MSB:ocs_pkg::SEL_LSB]; // [R19]
          end
        end
        ocs_pkg::ADDR_PORT_A_PULLUP: begin
          pin_sel_nxt = reg_wdata_i[ocs_pkg::BIT_PIN_SELECT];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        ocs_pkg::ADDR_OSC_STATUS: begin
          rdata_nxt[ocs_pkg::BIT_EXT_REQUEST] = req_r;
          rdata_nxt[ocs_pkg::BIT_EXT_ENGAGED] = engaged_r; // [R22]
        end
        ocs_pkg::ADDR_SECOND_CONFIG: begin
          rdata_nxt[ocs_pkg::SEL_MSB:ocs_pkg::SEL_LSB] = sel_r;
        end
        ocs_pkg::ADDR_PORT_A_PULLUP: begin
          rdata_nxt[ocs_pkg::BIT_PIN_SELECT] = pin_sel_r;
        end
        default: begin
          rdata_nxt = ocs_pkg::DATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_r <= 1'b0; // [R21]
      sel_r <= ocs_pkg::SEL_RESET; // [R23]
      pin_sel_r <= 1'b0;
      rdata_r <= ocs_pkg::DATA_ZERO;
    end else begin
      req_r <= req_nxt;
      sel_r <= sel_nxt;
      pin_sel_r <= pin_sel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ********************************
  // source selection
  // ********************************
  always_comb begin
    case (sel_r) // [R19]
      ocs_pkg::SRC_EXTERNAL: ext_lvl = osc_input_pin_i; // [R10]
      ocs_pkg::SRC_RC: ext_lvl = rc_clock_i;
      ocs_pkg::SRC_CRYSTAL: ext_lvl = crystal_clock_i;
      default: ext_lvl = 1'b0;
    endcase
  end

  assign ext_rise = ext_lvl & ~ext_prev_r;
  // internal path carries the nominal INTERNAL_NOMINAL_KHZ clock until the switch [R20]
  assign src_lvl = use_ext_r ? ext_lvl : internal_clock_i; // [R14]

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_lvl;
    end
  end

  // ********************************
  // switch-over sequence
  // ********************************
  always_comb begin
    state_nxt = state_r;
    edge_cnt_nxt = edge_cnt_r;
    use_ext_nxt = use_ext_r;
    engaged_nxt = engaged_r;
    int_off_nxt = int_off_r;
    case (state_r)
      ocs_pkg::OCS_ST_INTERNAL: begin
        edge_cnt_nxt = ocs_pkg::EDGE_ZERO;
        if (req_r && sel_r != ocs_pkg::SRC_INTERNAL && !bypass_mode_i) begin // [R24] [R21]
          state_nxt = ocs_pkg::OCS_ST_CHECK;
        end
      end
      ocs_pkg::OCS_ST_CHECK: begin
        if (!req_r) begin
          state_nxt = ocs_pkg::OCS_ST_INTERNAL;
        end else if (ext_rise) begin
          edge_cnt_nxt = edge_cnt_r + ocs_pkg::EDGE_ONE; // [R5]
          if (edge_cnt_r == ocs_pkg::EDGES_NEEDED - ocs_pkg::EDGE_ONE) begin
            state_nxt = ocs_pkg::OCS_ST_SWAP;
          end
        end
      end
      ocs_pkg::OCS_ST_SWAP: begin
        // both sources low: the mux flips inside a low phase, so no runt pulse
        if (!req_r) begin
          state_nxt = ocs_pkg::OCS_ST_INTERNAL;
        end else if (!internal_clock_i && !ext_lvl) begin // [R6]
          use_ext_nxt = 1'b1;
          engaged_nxt = 1'b1; // [R7]
          state_nxt = ocs_pkg::OCS_ST_HALT;
        end
      end
      ocs_pkg::OCS_ST_HALT: begin
        int_off_nxt = 1'b1; // [R7]
        state_nxt = ocs_pkg::OCS_ST_EXTERNAL;
      end
      ocs_pkg::OCS_ST_EXTERNAL: begin
        // no clock monitor: nothing here leads back, only reset does
        state_nxt = ocs_pkg::OCS_ST_EXTERNAL; // [R8] [R9]
      end
      default: begin
        state_nxt = ocs_pkg::OCS_ST_INTERNAL;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ocs_pkg::OCS_ST_INTERNAL; // [R23]
      edge_cnt_r <= ocs_pkg::EDGE_ZERO;
      use_ext_r <= 1'b0;
      engaged_r <= 1'b0;
      int_off_r <= 1'b0; // [R8]
    end else begin
      state_r <= state_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      use_ext_r <= use_ext_nxt;
      engaged_r <= engaged_nxt;
      int_off_r <= int_off_nxt;
    end
  end

  // ********************************
  // oscillator enables and input pin
  // ********************************
  always_comb begin
    osc_en_o.internal_en = oscillator_run_enable_i & ~int_off_r; // [R13]
    osc_en_o.rc_en = oscillator_run_enable_i & (sel_r == ocs_pkg::SRC_RC);
    osc_en_o.crystal_en = oscillator_run_enable_i & (sel_r == ocs_pkg::SRC_CRYSTAL);
  end

  assign osc_input_is_clock_o = (sel_r != ocs_pkg::SRC_INTERNAL); // [R2]

  // ********************************
  // output clocks
  // ********************************
  // wait and break have no input here: only stop gates the clocks [R16] [R18]
  ocs_clk_out u_clk_out (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .src_lvl_i(src_lvl),
    .stop_mode_i(stop_mode_i),
    .quad_rate_clock_o(quad_rate_clock_o),
    .double_rate_clock_o(double_rate_clock_o)
  );

  // ********************************
  // clock output pin
  // ********************************
  always_comb begin
    pin.drive = port_a_bit_four_out_i;
    pin.oe = port_a_bit_four_oe_i;
    case (sel_r)
      ocs_pkg::SRC_CRYSTAL: begin
        // pin belongs to the crystal amplifier, digital driver released
        pin.drive = 1'b0; // [R2] [R11]
        pin.oe = 1'b0;
      end
      ocs_pkg::SRC_EXTERNAL: begin
        pin.drive = port_a_bit_four_out_i; // [R12]
        pin.oe = port_a_bit_four_oe_i;
      end
      default: begin
        if (pin_sel_r) begin
          pin.drive = quad_rate_clock_o; // [R11]
          pin.oe = 1'b1;
        end
      end
    endcase
  end

  assign osc_output_pin_o = pin.drive;
  assign osc_output_pin_oe_o = pin.oe;
  assign crystal_amp_on_pin_o = (sel_r == ocs_pkg::SRC_CRYSTAL);
  assign port_a_bit_four_in_o = (sel_r == ocs_pkg::SRC_CRYSTAL) ? 1'b0 : osc_output_pin_i;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_internal_no_switch: assert property ( // [R24]
    (state_r == ocs_pkg::OCS_ST_INTERNAL && sel_r == ocs_pkg::SRC_INTERNAL) |=> !use_ext_r)
    else $error("switch started with internal source selected");

  chk_bypass_ignores: assert property ( // [R21]
    (state_r == ocs_pkg::OCS_ST_INTERNAL && bypass_mode_i) |=> state_r == ocs_pkg::OCS_ST_INTERNAL)
    else $error("request acted on in bypass mode");

  chk_two_edges: assert property ( // [R5]
    $rose(use_ext_r) |-> $past(edge_cnt_r) == ocs_pkg::EDGES_NEEDED)
    else $error("switched before two source edges");

  chk_glitch_free: assert property ( // [R6]
    $rose(use_ext_r) |-> $past(!internal_clock_i && !ext_lvl))
    else $error("mux switched outside a common low phase");

  chk_engaged_first: assert property ( // [R7]
    $rose(int_off_r) |-> $past(engaged_r) && !$past(int_off_r, 2))
    else $error("internal oscillator stopped before engaged was set");

  chk_engaged_halt: assert property ( // [R7]
    $rose(engaged_r) |=> int_off_r ##1 int_off_r)
    else $error("internal oscillator not stopped after engage");

  chk_no_fallback: assert property ( // [R8] [R9]
    use_ext_r |=> use_ext_r && osc_en_o.internal_en == 1'b0)
    else $error("fell back to internal clock");

  chk_engaged_read: assert property ( // [R22]
    (reg_rd_i && reg_addr_i == ocs_pkg::ADDR_OSC_STATUS) |=> reg_rdata_o[ocs_pkg::BIT_EXT_ENGAGED] == $past(engaged_r))
    else $error("engaged bit read back wrong");

  chk_input_clock_pin: assert property ( // [R2]
    sel_r != ocs_pkg::SRC_INTERNAL |-> osc_input_is_clock_o)
    else $error("input pin not set as clock input");

  chk_crystal_pin: assert property ( // [R11]
    sel_r == ocs_pkg::SRC_CRYSTAL |-> !osc_output_pin_oe_o && crystal_amp_on_pin_o)
    else $error("output pin driven in crystal mode");

  chk_external_pin: assert property ( // [R12]
    sel_r == ocs_pkg::SRC_EXTERNAL |-> osc_output_pin_o == port_a_bit_four_out_i && osc_output_pin_oe_o == port_a_bit_four_oe_i)
    else $error("output pin not port bit in external mode");

  chk_quad_on_pin: assert property ( // [R11]
    (sel_r == ocs_pkg::SRC_RC && pin_sel_r) |-> osc_output_pin_oe_o && osc_output_pin_o == quad_rate_clock_o)
    else $error("quad clock missing on output pin");

endmodule // ocs_switch
`default_nettype wire

// ---- tb/ocs_src_model.sv ----
// partner model: internal, rc and crystal oscillators and the external clock on the input pin
// assumes ref_clk_i is the bench clock; every source is a slow level sampled by the block
`timescale 1ns/1ps
`default_nettype none
module ocs_src_model (
  input wire logic ref_clk_i,
  input wire logic ext_run_i,
  output logic internal_clock_o = 1'b0,
  output logic rc_clock_o = 1'b0,
  output logic crystal_clock_o = 1'b0,
  output logic osc_input_pin_o = 1'b0
);
  // start values sit on the declarations so that each source has one driving process
  int cnt = 0;
  // periods of 4, 6, 10 and 6 reference cycles keep every edge visible to the sampler
  always @(posedge ref_clk_i) begin
    cnt <= cnt + 1;
    internal_clock_o <= cnt[1];
    rc_clock_o <= (cnt % 6) < 3;
    crystal_clock_o <= (cnt % 10) < 5;
    // a dead external clock stands still low, it does not keep its last phase
    osc_input_pin_o <= ext_run_i && ((cnt % 6) < 3);
  end
endmodule // ocs_src_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the clock source select and switch-over block
// assumes the partner model supplies every source clock; 125 MHz reference clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] REQ = 8'h01 << ocs_pkg::BIT_EXT_REQUEST;
  localparam logic [7:0] ENG = 8'h01 << ocs_pkg::BIT_EXT_ENGAGED;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, run_en = 1'b1, stop_m = 1'b0, byp = 1'b0;
  logic pa_out = 1'b0, pa_oe = 1'b0, ext_run = 1'b1;
  logic [7:0] rdata, v;
  logic quad, dbl, is_clk, pin_o, pin_oe, amp, pa_in, i_clk, r_clk, x_clk, e_pin;
  logic mon = 1'b0, psrc = 1'b0, pq = 1'b0, pd = 1'b0, msel = 1'b0;
  ocs_pkg::ocs_osc_en_t osc_en;
  int fails = 0, tests_run = 0, cyc = 0, n, qr, dc, s;
  // undriven pin is held high by the port pull-up
  wire logic pin = pin_oe ? pin_o : (pa_oe ? pa_out : 1'b1);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  ocs_src_model ocs_src_model_i (.ref_clk_i(ref_clk), .ext_run_i(ext_run), .internal_clock_o(i_clk),
    .rc_clock_o(r_clk), .crystal_clock_o(x_clk), .osc_input_pin_o(e_pin));

  ocs_switch ocs_switch_i (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .internal_clock_i(i_clk), .rc_clock_i(r_clk),
    .crystal_clock_i(x_clk), .osc_input_pin_i(e_pin), .oscillator_run_enable_i(run_en),
    .stop_mode_i(stop_m), .bypass_mode_i(byp), .quad_rate_clock_o(quad), .double_rate_clock_o(dbl),
    .osc_en_o(osc_en), .osc_input_is_clock_o(is_clk), .osc_output_pin_i(pin), .osc_output_pin_o(pin_o),
    .osc_output_pin_oe_o(pin_oe), .crystal_amp_on_pin_o(amp), .port_a_bit_four_out_i(pa_out),
    .port_a_bit_four_oe_i(pa_oe), .port_a_bit_four_in_o(pa_in));

  // ********************************
  // shared tasks
  // ********************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // reference model: quad is the selected source one cycle late, double moves once per quad rise
  always @(negedge ref_clk) begin
    if (mon) begin
      chk("quad", {7'h0, psrc}, {7'h0, quad});
      qr += int'(quad && !pq);
      dc += int'(dbl != pd);
    end
    psrc = msel ? e_pin : i_clk;
    pq = quad;
    pd = dbl;
  end

  // hang guard: the whole sequence needs well under 1500 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      $display("MISMATCH timeout expected finish seen hang");
      conclude();
    end
  end

  // ********************************
  // main sequence
  // ********************************
  initial begin
    v = 8'($urandom(56));
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rreg(ocs_pkg::ADDR_OSC_STATUS, v);
    chk("status", 8'h00, v);
    rreg(ocs_pkg::ADDR_SECOND_CONFIG, v);
    chk("select", 8'h00, v);
    rreg(4'hF, v);
    chk("unmapped", 8'h00, v);
    $display("test reset done");

    for (int k = 0; k < 8; k++) begin
      s = k % 4;
      if (s == 3) begin
        // crystal start-up aid: port bit four driven high before the crystal is selected
        @(posedge ref_clk);
        pa_out <= 1'b1;
        pa_oe <= 1'b1;
        tick(4);
        if (k < 4) chk("precharge", 8'h03, {6'h0, pin_oe, pin_o});
      end
      wreg(ocs_pkg::ADDR_SECOND_CONFIG, 8'(s));
      wreg(ocs_pkg::ADDR_PORT_A_PULLUP, 8'(k / 4) << ocs_pkg::BIT_PIN_SELECT);
      pa_out <= 1'($urandom);
      pa_oe <= 1'($urandom);
      tick(1);
      chk("is_clock", 8'(s != 0), {7'h0, is_clk});
      chk("amp", 8'(s == 3), {7'h0, amp});
      chk("pin_oe", s == 3 ? 8'h00 : (s != 1 && k >= 4) ? 8'h01 : {7'h0, pa_oe}, {7'h0, pin_oe});
      chk("pin_o", s == 3 ? 8'h00 : (s != 1 && k >= 4) ? {7'h0, quad} : {7'h0, pa_out}, {7'h0, pin_o});
      chk("port_in", s == 3 ? 8'h00 : {7'h0, pin}, {7'h0, pa_in});
      chk("osc_en", 8'h03, {6'h0, osc_en.internal_en, s == 2 ? osc_en.rc_en : s == 3 ? osc_en.crystal_en : 1'b1});
    end
    $display("test select and pin done");

    wreg(ocs_pkg::ADDR_SECOND_CONFIG, 8'(ocs_pkg::SRC_INTERNAL));
    run_en <= 1'b0;
    tick(1);
    chk("run_off", 8'h00, {7'h0, osc_en.internal_en});
    @(posedge ref_clk);
    run_en <= 1'b1;
    wreg(ocs_pkg::ADDR_OSC_STATUS, REQ);
    mon = 1'b1;
    tick(40);
    mon = 1'b0;
    rreg(ocs_pkg::ADDR_OSC_STATUS, v);
    chk("no_switch", REQ, v);
    $display("test internal request done");

    wreg(ocs_pkg::ADDR_OSC_STATUS, 8'h00);
    wreg(ocs_pkg::ADDR_SECOND_CONFIG, 8'(ocs_pkg::SRC_EXTERNAL));
    byp <= 1'b1;
    wreg(ocs_pkg::ADDR_OSC_STATUS, REQ);
    tick(40);
    rreg(ocs_pkg::ADDR_OSC_STATUS, v);
    chk("bypass", REQ, v);
    msel = 1'b1;
    @(posedge ref_clk);
    byp <= 1'b0;
    n = 0;
    do begin
      rreg(ocs_pkg::ADDR_OSC_STATUS, v);
      n++;
      if (v === REQ) chk("int_before", 8'h01, {7'h0, osc_en.internal_en});
    end while (v !== (REQ | ENG) && n < 30);
    chk("engaged", REQ | ENG, v);
    chk("edges_awaited", 8'h01, 8'(n >= 3));
    tick(1);
    chk("int_off", 8'h00, {7'h0, osc_en.internal_en});
    qr = 0;
    dc = 0;
    mon = 1'b1;
    tick(60);
    mon = 1'b0;
    chk("double", 8'h01, 8'(qr > 5 && dc - qr <= 1 && qr - dc <= 1));
    $display("test switch done");

    @(posedge ref_clk);
    ext_run <= 1'b0;
    tick(30);
    rreg(ocs_pkg::ADDR_OSC_STATUS, v);
    chk("no_fallback", REQ | ENG, v);
    chk("int_stays_off", 8'h00, {7'h0, osc_en.internal_en});
    @(posedge ref_clk);
    ext_run <= 1'b1;
    stop_m <= 1'b1;
    tick(12);
    repeat (8) begin
      tick(1);
      chk("stop", 8'h00, {7'h0, quad});
    end
    @(posedge ref_clk);
    stop_m <= 1'b0;
    $display("test dead clock and stop done");

    rst_b <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rreg(ocs_pkg::ADDR_OSC_STATUS, v);
    chk("status_again", 8'h00, v);
    chk("int_back", 8'h01, {7'h0, osc_en.internal_en});
    msel = 1'b0;
    tick(2);
    mon = 1'b1;
    tick(30);
    mon = 1'b0;
    $display("test second reset done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
